// file: common/asc_consts.svh
// timing and geometry constants for the async sram host controller
// assumes a 10 MHz mclk; figures in ns, counts derived by ceiling, at least one cycle
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
`define ASC_CLK_PERIOD_NS   100
`define ASC_ADDR_W          19
`define ASC_DATA_W          8
// slower grade is the default; least times round up
`define ASC_READ_CYCLE_NS   100
`define ASC_ACCESS_NS       100
`define ASC_OE_VALID_NS     40
`define ASC_FLOAT_NS        35
`define ASC_WRITE_CYCLE_NS  70
`define ASC_CW_NS           60
`define ASC_AW_NS           60
`define ASC_DW_NS           45
`define ASC_WR_NS           5
`define ASC_CEIL(ns)        (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_MIN1(n)         (((n) < 1) ? 1 : (n))
`define ASC_READ_CYC        `ASC_MIN1(`ASC_CEIL(`ASC_ACCESS_NS) + 1)
`define ASC_WRITE_CYC       `ASC_MIN1(`ASC_CEIL(`ASC_CW_NS))
`define ASC_REC_CYC         `ASC_MIN1(`ASC_CEIL(`ASC_WR_NS))
`define ASC_FLOAT_CYC       `ASC_MIN1(`ASC_CEIL(`ASC_FLOAT_NS))
`endif

// file: common/asc_pkg.sv
// types for the async sram host controller
// assumes asc_consts.svh is on the include path
`include "asc_consts.svh"
package asc_pkg;
   typedef struct packed {
      logic                   wr;
      logic [`ASC_ADDR_W-1:0] addr;
      logic [`ASC_DATA_W-1:0] wdata;
   } asc_req_t;
   typedef enum logic [2:0] {ST_IDLE, ST_FLOAT, ST_READ, ST_WRITE, ST_RECOVER} asc_state_t;
endpackage

// file: src/asc_host.sv
// host controller driving a 512k x 8 asynchronous static ram over its pins
// assumes the ram sits directly on the pins; read data comes back through a 2-flop synchroniser
//
// Contract
// [R1] enable-to-data within access time before sampling
// [R2] output enable to data valid respected
// [R3] device drives no earlier than enable
// [R4] device drives no earlier than output enable
// [R5] device floats after enable deasserted
// [R6] device floats after output enable deasserted
// [R7] old data held briefly after address change
// [R8] enables held active long enough before write end
// [R9] address stable before write end, zero setup
// [R10] write data set up before terminating edge
// [R11] write data held through terminating edge
// [R12] device floats after write strobe falls
// [R13] memory written only during full overlap
// [R14] write starts on all three, any ends
// [R15] data timed against terminating edge
// [R16] recovery wait after write ends
// [R17] no opposing drive while device drives
// [R18] output enable held high during write
// [R19] read drives stored byte when enabled
// [R20] deselected device ignores strobe, floats
// [R21] next access waits minimum cycle time
`timescale 1ns/100ps
`include "asc_consts.svh"
module asc_host #(
   parameter int READ_CYC  = `ASC_READ_CYC,
   parameter int WRITE_CYC = `ASC_WRITE_CYC,
   parameter int REC_CYC   = `ASC_REC_CYC,
   parameter int FLOAT_CYC = `ASC_FLOAT_CYC
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic                   req_valid,
   input  wire asc_pkg::asc_req_t      req,
   output logic                        req_ready,
   output logic                        rsp_valid,
   output logic [`ASC_DATA_W-1:0]      rsp_data,
   output logic [`ASC_ADDR_W-1:0]      word_select_lines,
   output logic                        chip_select_low_n,
   output logic                        chip_select_high,
   output logic                        output_enable_n,
   output logic                        write_strobe_n,
   input  wire logic [`ASC_DATA_W-1:0] data_lines_in,
   output logic [`ASC_DATA_W-1:0]      data_lines_out,
   output logic                        data_lines_oe_n
);
   localparam int CNT_W = 8;
   asc_pkg::asc_state_t        state_q;
   logic [CNT_W-1:0]           cnt_q;
   logic [`ASC_DATA_W-1:0]     sync1_q;
   logic [`ASC_DATA_W-1:0]     sync2_q;
   logic                       pend_wr_q;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: the ram answers asynchronously to mclk
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= data_lines_in;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer; every access takes at least its cycle time [R21]
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q           <= asc_pkg::ST_IDLE;
         cnt_q             <= '0;
         pend_wr_q         <= 1'b0;
         req_ready         <= 1'b0;
         rsp_valid         <= 1'b0;
         rsp_data          <= '0;
         word_select_lines <= '0;
         chip_select_low_n <= 1'b1;
         chip_select_high  <= 1'b0;
         output_enable_n   <= 1'b1;
         write_strobe_n    <= 1'b1;
         data_lines_out    <= '0;
         data_lines_oe_n   <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         case (state_q)
            asc_pkg::ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready         <= 1'b0;
                  // address set up FLOAT_CYC cycles ahead of the enables [R9]
                  word_select_lines <= req.addr;
                  data_lines_out    <= req.wdata;
                  pend_wr_q         <= req.wr;
                  state_q           <= asc_pkg::ST_FLOAT;
                  cnt_q             <= CNT_W'(FLOAT_CYC);
               end
            end
            asc_pkg::ST_FLOAT: begin
               // wait for the ram to release the bus before we drive it [R5] [R6] [R17]
               if (cnt_q > CNT_W'(1)) begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end else if (pend_wr_q) begin
                  // all three qualifiers go active together; oe stays high [R14] [R18]
                  chip_select_low_n <= 1'b0;
                  chip_select_high  <= 1'b1;
                  write_strobe_n    <= 1'b0;
                  data_lines_oe_n   <= 1'b0; // [R10]
                  state_q           <= asc_pkg::ST_WRITE;
                  cnt_q             <= CNT_W'(WRITE_CYC);
               end else begin
                  chip_select_low_n <= 1'b0;
                  chip_select_high  <= 1'b1;
                  output_enable_n   <= 1'b0; // [R19]
                  state_q           <= asc_pkg::ST_READ;
                  cnt_q             <= CNT_W'(READ_CYC + 2);
               end
            end
            asc_pkg::ST_READ: begin
               // extra cycles cover access time plus synchroniser depth [R1] [R2] [R3] [R4]
               if (cnt_q > CNT_W'(1)) begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end else begin
                  rsp_data          <= sync2_q; // [R7]
                  rsp_valid         <= 1'b1;
                  chip_select_low_n <= 1'b1;
                  chip_select_high  <= 1'b0;
                  output_enable_n   <= 1'b1;
                  state_q           <= asc_pkg::ST_RECOVER;
                  cnt_q             <= CNT_W'(FLOAT_CYC);
               end
            end
            asc_pkg::ST_WRITE: begin
               // strobe alone terminates; data and address held past that edge [R8] [R11] [R13] [R15]
               if (cnt_q > CNT_W'(1)) begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end else begin
                  write_strobe_n <= 1'b1; // [R14]
                  state_q        <= asc_pkg::ST_RECOVER;
                  cnt_q          <= CNT_W'(REC_CYC);
               end
            end
            asc_pkg::ST_RECOVER: begin
               // enables and data drop one cycle after the strobe, then the recovery count runs out [R16] [R20] [R12]
               chip_select_low_n <= 1'b1;
               chip_select_high  <= 1'b0;
               data_lines_oe_n   <= 1'b1;
               if (cnt_q > CNT_W'(1)) begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end else begin
                  state_q <= asc_pkg::ST_IDLE;
               end
            end
            default: state_q <= asc_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on what this controller drives
   sequence s_write_pulse;
      !write_strobe_n [*1] ##0 !chip_select_low_n && chip_select_high;
   endsequence

   a_no_contention: assert property (@(posedge mclk) disable iff (!reset_n) // [R17]
      !data_lines_oe_n |-> output_enable_n)
      else $error("host drives data while ram output enabled");
   a_oe_high_write: assert property (@(posedge mclk) disable iff (!reset_n) // [R18]
      !write_strobe_n |-> output_enable_n)
      else $error("output enable low during write");
   a_write_overlap: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
      !write_strobe_n |-> (!chip_select_low_n && chip_select_high && !data_lines_oe_n))
      else $error("write strobe outside full overlap");
   a_strobe_width: assert property (@(posedge mclk) disable iff (!reset_n) // [R8]
      $fell(write_strobe_n) |-> !write_strobe_n [*1] ##0 s_write_pulse)
      else $error("write pulse too short");
   a_data_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
      $rose(write_strobe_n) |-> !data_lines_oe_n && $stable(data_lines_out) && $stable(word_select_lines))
      else $error("data or address changed at write end");
   a_addr_stable: assert property (@(posedge mclk) disable iff (!reset_n) // [R9]
      (!write_strobe_n && $past(!write_strobe_n)) |-> $stable(word_select_lines))
      else $error("address moved during write");
   a_write_start: assert property (@(posedge mclk) disable iff (!reset_n) // [R14]
      $fell(write_strobe_n) |-> $fell(chip_select_low_n) && $rose(chip_select_high))
      else $error("write began before enables");
   a_read_resp: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
      $fell(output_enable_n) |-> ##[1:40] rsp_valid)
      else $error("read response missing");
   a_recover: assert property (@(posedge mclk) disable iff (!reset_n) // [R16]
      $rose(write_strobe_n) |=> chip_select_low_n && !chip_select_high && data_lines_oe_n)
      else $error("no recovery after write");
   // enables and write data must already stand one sample before the strobe rises
   a_write_lead: assert property (@(posedge mclk) disable iff (!reset_n) // [R8] [R10]
      $rose(write_strobe_n) |-> $past(!chip_select_low_n && chip_select_high && !data_lines_oe_n))
      else $error("enables or data not set up before write end");
endmodule

// file: dv/asc_sram_model.sv
// behavioural model of the 512k x 8 static ram seen from the host pins
// assumes host write data and its enable arrive apart; hands back the resolved wire
`timescale 1ns/100ps
`include "asc_consts.svh"
module asc_sram_model (
   input  wire logic [`ASC_ADDR_W-1:0] addr,
   input  wire logic                   cs_low_n,
   input  wire logic                   cs_high,
   input  wire logic                   oe_n,
   input  wire logic                   we_n,
   input  wire logic [`ASC_DATA_W-1:0] host_d,
   input  wire logic                   host_oe_n,
   output logic [`ASC_DATA_W-1:0]      line,
   output logic                        bad
);
   logic [`ASC_DATA_W-1:0] mem [0:(1<<`ASC_ADDR_W)-1];
   logic [`ASC_DATA_W-1:0] rd_q = 8'h00;
   logic                   sel;
   logic                   drv;
   realtime                t_sel = 0;
   realtime                t_d = 0;
   ////////////////////////////////////////////////////////////////////////////
   // select and drive; slow grade figures, float taken at the tighter 30 ns
   assign sel = !cs_low_n && cs_high;
   assign #(15, 30) drv = sel && we_n && !oe_n;
   // old byte kept 10 ns, then scrambled so an early sample shows up wrong
   always @(addr or sel) begin
      rd_q <= #10 ~rd_q;
      rd_q <= #100 mem[addr];
   end
   // store only inside the full overlap; a floating wire stores garbage
   always @* if (sel && !we_n) mem[addr] = host_oe_n ? ~host_d : host_d;
   // released wire shows the inverse, never a kind leftover value
   assign line = !host_oe_n ? host_d : (drv ? rd_q : ~rd_q);
   ////////////////////////////////////////////////////////////////////////////
   // host timing is judged here and flagged to the bench
   initial bad = 1'b0;
   always @(negedge cs_low_n) t_sel = $realtime;
   always @(host_d or host_oe_n) t_d = $realtime;
   always @(posedge we_n) if (sel && ($realtime - t_sel < 60 || $realtime - t_d < 45 || host_oe_n)) bad = 1'b1;
   always @* if (drv && !host_oe_n) bad = 1'b1;
endmodule

// file: dv/asc_host_tb.sv
// self-checking bench for the async sram host controller
// assumes the ram model sits on the pins and requests go one at a time
`timescale 1ns/100ps
`include "asc_consts.svh"
module asc_host_tb;
   logic                   mclk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   req_valid = 1'b0;
   asc_pkg::asc_req_t      req = '0;
   logic                   req_ready, rsp_valid, cs_low_n, cs_high, oe_n, we_n, d_oe_n, bad;
   logic [`ASC_DATA_W-1:0] rsp_data, d_out, d_in;
   logic [`ASC_ADDR_W-1:0] wsl;
   int                     err_count = 0;
   int                     check_count = 0;
   always #50 mclk = ~mclk;
   asc_host asc_host_i (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .word_select_lines(wsl),
      .chip_select_low_n(cs_low_n), .chip_select_high(cs_high), .output_enable_n(oe_n),
      .write_strobe_n(we_n), .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe_n(d_oe_n));
   asc_sram_model asc_sram_model_i (.addr(wsl), .cs_low_n(cs_low_n), .cs_high(cs_high), .oe_n(oe_n),
      .we_n(we_n), .host_d(d_out), .host_oe_n(d_oe_n), .line(d_in), .bad(bad));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (err_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one request, held until taken; ready must drop once busy
   task automatic send(input logic wr, input logic [18:0] a, input logic [7:0] d);
      int n;
      n = 0;
      // let an edge pass first so a back-to-back call never re-drives valid in one step
      @(posedge mclk); #1;
      req_valid = 1'b1;
      req = '{wr, a, d};
      while (req_ready !== 1'b1 && n < 50) begin @(posedge mclk); #1; n++; end
      if (req_ready !== 1'b1) begin err_count++; test_done(); end
      @(posedge mclk); #1;
      req_valid = 1'b0;
      chk({7'h00, req_ready}, 8'h00);
   endtask
   task automatic rd(input logic [18:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      send(1'b0, a, 8'h00);
      while (rsp_valid !== 1'b1 && n < 20) begin @(posedge mclk); #1; n++; end
      if (rsp_valid !== 1'b1) begin err_count++; test_done(); end
      chk(rsp_data, exp);
   endtask
   // strobe low must find output enable high; model timing flag stays clear
   // sampled mid-cycle, where the registered pins have settled
   always @(negedge mclk) if (reset_n && we_n === 1'b0) chk({7'h00, oe_n}, 8'h01);
   always @(negedge mclk) if (reset_n) chk({7'h00, bad}, 8'h00);
   ////////////////////////////////////////////////////////////////////////////
   task automatic sc_bounds(); // end addresses, back to back
      send(1'b1, 19'h0_0000, 8'ha5);
      send(1'b1, 19'h7_ffff, 8'h5a);
      rd(19'h0_0000, 8'ha5);
      rd(19'h7_ffff, 8'h5a);
      rd(19'h0_0000, 8'ha5);
   endtask
   task automatic sc_reset_mid(); // reset in mid-read drops the enables at once
      send(1'b1, 19'h1_2345, 8'h3c);
      send(1'b0, 19'h1_2345, 8'h00);
      @(posedge mclk); #1;
      @(posedge mclk); #1;
      // read under way: enables and output enable active, host not driving
      chk({4'h0, cs_low_n, cs_high, oe_n, d_oe_n}, 8'h05);
      reset_n = 1'b0;
      #1 chk({4'h0, cs_low_n, cs_high, oe_n, d_oe_n}, 8'h0b);
      @(posedge mclk); #1;
      reset_n = 1'b1;
      send(1'b1, 19'h1_2345, 8'hc3);
      rd(19'h1_2345, 8'hc3);
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      #1 reset_n = 1'b1;
      sc_bounds();
      sc_reset_mid();
      repeat (4) @(posedge mclk);
      test_done();
   end
endmodule
